// ===== design/socket_state_defines.svh
/*
 Offsets, field positions, reset values and masks for the card socket
 status block. Assumes inclusion by bare name from the design files.
*/
`ifndef SOCKET_STATE_DEFINES_SVH
`define SOCKET_STATE_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_SOCKET_EVENT   12'h000
`define OFS_SOCKET_MASK    12'h004
`define OFS_SOCKET_STATUS  12'h008
`define OFS_FORCE_EVENT    12'h00C
`define OFS_SOCKET_CTRL    12'h010
`define OFS_SEQ_INPUTS     12'h014

// ----------------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------------
`define B_SUPPLY_Y     31
`define B_SUPPLY_X     30
`define B_SUPPLY_3V3   29
`define B_SUPPLY_5V0   28
`define B_CARD_Y       13
`define B_CARD_5V0     10
`define B_BAD_VCC      9
`define B_DATA_LOSS    8
`define B_NOT_CARD     7
`define B_READY_IRQ    6
`define B_CARDBUS      5
`define B_SIXTEEN      4
`define B_POWER        3
`define B_DETECT2      2
`define B_DETECT1      1
`define B_STSCHG       0
`define B_CVS_TEST     14

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define STATUS_RESET   32'h3000_0000
`define EVENT_BITS     4

`endif

// ===== design/socket_state_pkg.sv
/*
 Types for the card socket status block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package socket_state_pkg;
   typedef enum logic [1:0] {
      HTRANS_IDLE   = 2'h0,
      HTRANS_BUSY   = 2'h1,
      HTRANS_NONSEQ = 2'h2,
      HTRANS_SEQ    = 2'h3
   } htrans_e;

   typedef enum logic [2:0] {
      ST_EMPTY = 3'b001,
      ST_IDENT = 3'b010,
      ST_READY = 3'b100
   } socket_e;
endpackage : socket_state_pkg

// ===== design/socket_present_state.sv
/*
 Card socket status register bank on an AHB-Lite slave: event, mask,
 status, force-event, power control and interrogation input registers.
 Assumes card pins are asynchronous to CORE_CLK; one bus master; single
 word transfers.
*/
// The AHB-Lite slave port is this design's own decision.
// Overview of operation
// - Status register is read-only at 08h, reset value 3000_00XXh.
// - Bits 31 and 30 supply capability always read zero.
// - Bits 29, 28 read one unless force-event overrides them.
// - Bits 27 to 14 always read zero.
// - Bits 13 to 10 show card voltage support, force-event can set them.
// - Card voltage bits refresh at insertion and again at each reinterrogation requested by force-event bit 14; type bits only when a card is recognised.
// - Bit 9 flags an invalid power request, default zero.
// - Bit 8 flags possible data loss on removal, default zero.
// - Bit 7 flags unrecognised card, held until a valid card arrives.
// - Bit 6 mirrors the ready/interrupt pin level.
// - Bits 5, 4 flag CardBus or 16-bit card, held until an interrogation recognises a card.
// - Bit 3 shows socket power state, zero when powered down.
// - Bits 2, 1 follow the card-detect pin levels.
// - Detect bits frozen while the pins are used for identification.
// - Bit 0 follows the status-change pin level.
// - Force-event writes at 0Ch appear in status bits 29, 28, 13 to 7, 5 and 4; bits 3 to 0 set the event bits.
// - Power state change sets event bit 3, cleared by writing one.
// - Status-change event on rising edge for CardBus, both edges 16-bit.
`timescale 1ns/1ps
`include "socket_state_defines.svh"

module socket_present_state
   import socket_state_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        ARST_N,
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic [31:0]      HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        CARD_DETECT_PIN_ONE,
   input  wire logic        CARD_DETECT_PIN_TWO,
   input  wire logic        CARD_STATUS_CHANGE_PIN,
   input  wire logic        CARD_READY_IRQ_PIN,
   output logic             IRQ,
   output logic             SOCKET_POWER_ON,
   output logic             IDENT_ACTIVE
);

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         // Idle levels: detect high, status change and ready low
         pin_meta <= 4'h3;
         pin_sync <= 4'h3;
      end else begin
         pin_meta <= {CARD_READY_IRQ_PIN, CARD_STATUS_CHANGE_PIN,
                      CARD_DETECT_PIN_TWO, CARD_DETECT_PIN_ONE};
         pin_sync <= pin_meta;
      end
   end

   logic cd1_s;
   logic cd2_s;
   logic sts_s;
   logic rdy_s;
   assign cd1_s = pin_sync[0];
   assign cd2_s = pin_sync[1];
   assign sts_s = pin_sync[2];
   assign rdy_s = pin_sync[3];

   // ----------------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------------
   logic        wr_pend;
   logic [11:0] wr_addr;
   logic        ap_take;
   logic        rd_take;
   logic        wr_now;

   assign ap_take = HSEL && HREADY && HTRANS[1];
   assign rd_take = ap_take && !HWRITE;
   assign wr_now  = wr_pend;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else begin
         wr_pend <= ap_take && HWRITE;
         wr_addr <= HADDR;
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Software written registers
   // ----------------------------------------------------------------------
   logic [3:0]  mask;
   logic [2:0]  power_req;
   logic        cvs_req;
   logic [3:0]  seq_in;
   logic [13:0] force_wr;
   logic        force_hit;
   logic        ctrl_hit;

   assign force_hit = wr_now && (wr_addr == `OFS_FORCE_EVENT);
   assign ctrl_hit  = wr_now && (wr_addr == `OFS_SOCKET_CTRL);
   assign force_wr  = HWDATA[13:0];

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         mask      <= 4'h0;
         power_req <= 3'h0;
         seq_in    <= 4'h0;
      end else begin
         if (wr_now && (wr_addr == `OFS_SOCKET_MASK))
            mask <= HWDATA[3:0];
         if (ctrl_hit)
            power_req <= HWDATA[2:0];
         if (wr_now && (wr_addr == `OFS_SEQ_INPUTS))
            seq_in <= HWDATA[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // Insertion and interrogation sequencer
   // ----------------------------------------------------------------------
   socket_e state;
   logic    both_low;

   assign both_low = !cd1_s && !cd2_s;
   assign cvs_req  = force_hit && HWDATA[`B_CVS_TEST];

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_EMPTY;
      end else begin
         case (state)
            ST_EMPTY: begin
               if (both_low || cvs_req)
                  state <= ST_IDENT;
            end
            ST_IDENT: begin
               state <= ST_READY;
            end
            ST_READY: begin
               if (cvs_req)
                  state <= ST_IDENT;
               else if (!both_low)
                  state <= ST_EMPTY;
            end
            default: state <= ST_EMPTY;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Status contents
   // ----------------------------------------------------------------------
   logic [1:0] supply_cap;
   logic [3:0] card_volt;
   logic       bad_vcc;
   logic       data_loss;
   logic       not_card;
   logic [1:0] card_type;
   logic       power_state;
   logic [1:0] detect;
   logic       ident_end;

   assign ident_end = (state == ST_IDENT);

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         supply_cap <= 2'b11;
      else if (force_hit)
         supply_cap <= HWDATA[`B_SUPPLY_3V3:`B_SUPPLY_5V0];
   end

   // card info latched at each interrogation (insertion or bit 14 reinterrogation) and on force writes
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         card_volt <= 4'h0;
         card_type <= 2'b00;
         not_card  <= 1'b0;
      end else if (force_hit) begin
         card_volt <= force_wr[`B_CARD_Y:`B_CARD_5V0];
         card_type <= force_wr[`B_CARDBUS:`B_SIXTEEN];
         not_card  <= force_wr[`B_NOT_CARD];
      end else if (ident_end) begin
         card_volt <= seq_in;
         card_type <= (seq_in == 4'h0) ? card_type : {seq_in[1], !seq_in[1]};
         not_card  <= (seq_in == 4'h0);
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         bad_vcc   <= 1'b0;
         data_loss <= 1'b0;
      end else begin
         if (force_hit)
            bad_vcc <= force_wr[`B_BAD_VCC];
         else if (ctrl_hit)
            bad_vcc <= (HWDATA[2:0] != 3'h0) && ((HWDATA[1:0] & card_volt[1:0]) == 2'b00);
         if (force_hit)
            data_loss <= force_wr[`B_DATA_LOSS];
         else if (state == ST_READY && !both_low && power_state)
            data_loss <= 1'b1;
      end
   end

   // power state follows valid power request while the socket is in ST_READY
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         power_state <= 1'b0;
      else
         power_state <= (power_req != 3'h0) && !bad_vcc && (state == ST_READY);
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         detect <= 2'b11;
      else if (state != ST_IDENT)
         detect <= {cd2_s, cd1_s};
   end

   logic [31:0] status;
   always_comb begin
      status = 32'h0000_0000;
      status[`B_SUPPLY_3V3:`B_SUPPLY_5V0] = supply_cap;
      status[`B_CARD_Y:`B_CARD_5V0] = card_volt;
      status[`B_BAD_VCC]   = bad_vcc;
      status[`B_DATA_LOSS] = data_loss;
      status[`B_NOT_CARD]  = not_card;
      status[`B_READY_IRQ] = rdy_s;
      status[`B_CARDBUS:`B_SIXTEEN] = card_type;
      status[`B_POWER]     = power_state;
      status[`B_DETECT2:`B_DETECT1] = detect;
      status[`B_STSCHG]    = sts_s;
   end

   // ----------------------------------------------------------------------
   // Events and interrupt
   // ----------------------------------------------------------------------
   logic [3:0] event_q;
   logic [3:0] prev;
   logic [3:0] hw_set;
   logic [3:0] clr;

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         prev <= 4'b0110;
      else
         prev <= {power_state, detect, sts_s};
   end

   always_comb begin
      hw_set[3] = power_state != prev[3];
      hw_set[2] = detect[1] != prev[2];
      hw_set[1] = detect[0] != prev[1];
      hw_set[0] = card_type[1] ? (sts_s && !prev[0]) : (sts_s != prev[0]);
      if (force_hit)
         hw_set = hw_set | force_wr[3:0];
      clr = (wr_now && (wr_addr == `OFS_SOCKET_EVENT)) ? HWDATA[3:0] : 4'h0;
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N)
         event_q <= 4'h0;
      else
         event_q <= (event_q & ~clr) | hw_set;
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         IRQ             <= 1'b0;
         SOCKET_POWER_ON <= 1'b0;
         IDENT_ACTIVE    <= 1'b0;
      end else begin
         IRQ             <= |(((event_q & ~clr) | hw_set) & mask);
         SOCKET_POWER_ON <= power_state;
         IDENT_ACTIVE    <= (state == ST_IDENT);
      end
   end

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   // reads have no side effect
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_take) begin
         case (HADDR)
            `OFS_SOCKET_EVENT:  HRDATA <= {28'h0000000, event_q};
            `OFS_SOCKET_MASK:   HRDATA <= {28'h0000000, mask};
            `OFS_SOCKET_STATUS: HRDATA <= status;
            `OFS_SOCKET_CTRL:   HRDATA <= {29'h00000000, power_req};
            `OFS_SEQ_INPUTS:    HRDATA <= {28'h0000000, seq_in};
            default:            HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_supply_high_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      status[31:30] == 2'b00) else $error("Unsupported supply bits set");
   a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      status[27:14] == 14'h0) else $error("Reserved status bits nonzero");
   a_supply_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !force_hit |=> $stable(supply_cap)) else $error("Supply cap changed without force");
   a_force_card: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      force_hit |=> card_volt == $past(HWDATA[13:10])) else $error("Force not reflected");
   a_info_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      (!force_hit && state != ST_IDENT) |=> $stable(card_volt) && $stable(card_type))
      else $error("Card info changed outside insertion");
   a_ready_mirror: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      status[6] == pin_sync[3]) else $error("Ready bit not mirroring pin");
   a_detect_freeze: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      state == ST_IDENT |=> $stable(detect)) else $error("Detect changed in ident");
   a_power_event: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      $changed(power_state) |=> event_q[3]) else $error("Power event missed");
   a_stschg_event: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      $rose(sts_s) |=> event_q[0]) else $error("Status change event missed");
   a_read_quiet: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      (rd_take && !wr_now && hw_set == 4'h0) |=> event_q == $past(event_q))
      else $error("Read altered events");
   a_stschg_fall: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      ($fell(sts_s) && !card_type[1]) |=> event_q[0])
      else $error("Falling status change missed");
   a_detect_track: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      state != ST_IDENT |=> detect == $past(pin_sync[1:0]))
      else $error("Detect not tracking pins");
   a_power_ready: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      power_state |-> $past(state) == ST_READY)
      else $error("Power on without ready card");
   a_ident_pulse: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      IDENT_ACTIVE |-> $past(state) == ST_IDENT)
      else $error("Ident flag outside interrogation");
   a_irq_masked: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      mask == 4'h0 |=> !IRQ)
      else $error("Interrupt while all masked");
   a_bus_okay: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      HREADYOUT && !HRESP)
      else $error("Bus not ready or not okay");

   // ----------------------------------------------------------------------
   // Covers
   // ----------------------------------------------------------------------
   c_reinterrogate: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
      cvs_req && state == ST_READY);
   c_insert: cover property (@(posedge CORE_CLK) disable iff (!ARST_N)
      state == ST_EMPTY ##1 state == ST_IDENT ##1 state == ST_READY);
   c_power_up: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $rose(power_state));
   c_irq: cover property (@(posedge CORE_CLK) disable iff (!ARST_N) $rose(IRQ));
endmodule : socket_present_state

// ===== bench/card_model.sv
/*
 Card in the socket: drives the detect, status-change and ready pins.
 Assumes the bench commands insertion and pin levels off the clock edge.
*/
`timescale 1ns/1ps

module card_model (
   input  wire logic inserted,
   input  wire logic sts_level,
   input  wire logic rdy_level,
   output logic      card_detect_pin_one,
   output logic      card_detect_pin_two,
   output logic      card_status_change_pin,
   output logic      card_ready_irq_pin
);
   // ----------------------------------------------------------------
   // Pin levels
   // ----------------------------------------------------------------
   // Detect pins pulled up while the socket is empty
   assign card_detect_pin_one    = ~inserted;
   assign card_detect_pin_two    = ~inserted;
   assign card_status_change_pin = sts_level;
   assign card_ready_irq_pin     = rdy_level;
endmodule : card_model

// ===== bench/tb_socket_present_state.sv
/*
 Self-checking bench for the card socket status block.
 Assumes the design answers with zero wait states and OKAY responses.
*/
`timescale 1ns/1ps
`include "socket_state_defines.svh"

module tb_socket_present_state;
   import socket_state_pkg::*;

   typedef struct packed {
      logic [1:0]  pins;
      logic [31:0] exp;
   } row_s;

   logic        core_clk, arst_n, hsel, hwrite, hreadyout, hresp, irq, power_on;
   logic        ident, inserted, sts, rdy, cd1, cd2, sts_pin, rdy_pin;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   int          errors, tests_run, idents;
   row_s        rows [4];

   socket_present_state dut_u (
      .CORE_CLK(core_clk), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .CARD_DETECT_PIN_ONE(cd1), .CARD_DETECT_PIN_TWO(cd2),
      .CARD_STATUS_CHANGE_PIN(sts_pin), .CARD_READY_IRQ_PIN(rdy_pin),
      .IRQ(irq), .SOCKET_POWER_ON(power_on), .IDENT_ACTIVE(ident));

   card_model card_u (
      .inserted(inserted), .sts_level(sts), .rdy_level(rdy),
      .card_detect_pin_one(cd1), .card_detect_pin_two(cd2),
      .card_status_change_pin(sts_pin), .card_ready_irq_pin(rdy_pin));

   // Interrogation pulses seen on the ident flag
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         idents <= 0;
      else if (ident === 1'b1)
         idents <= idents + 1;
   end

   // ----------------------------------------------------------------
   // Clock and helpers
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Single AHB-Lite word transfer, entered just after a rising edge
   task automatic ahb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rdat);
      int n;
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      hsize  <= 3'h2;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
         errors++;
      hsel   <= 1'b0;
      htrans <= HTRANS_IDLE;
      hwdata <= wd;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
         errors++;
      rdat = hrdata;
   endtask : ahb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      ahb(1'b1, a, d, dummy);
   endtask : wr

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : wrap_up

   initial begin
      #(40 * 5000);
      errors++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {arst_n, hsel, hwrite, inserted, sts, rdy} = 6'h0;
      haddr  = 12'h000;
      htrans = HTRANS_IDLE;
      hsize  = 3'h2;
      hwdata = 32'h0000_0000;
      errors = 0;
      tests_run = 0;
      rows = '{'{2'h0, 32'h3000_0006}, '{2'h1, 32'h3000_0007},
               '{2'h2, 32'h3000_0046}, '{2'h3, 32'h3000_0047}};
      tick(10);
      check({30'h0, hreadyout, hresp}, 32'h0000_0002);
      arst_n <= 1'b1;
      tick(4);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0006);
      $display("END reset");
      // Ready and status-change levels, pins {ready, status change}
      for (int i = 0; i < 4; i++) begin
         {rdy, sts} <= rows[i].pins;
         tick(4);
         ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
         check(rd, rows[i].exp);
      end
      {rdy, sts} <= 2'h0;
      wr(`OFS_SOCKET_STATUS, 32'hFFFF_FFFF);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0006);
      $display("END pin levels");
      // CardBus card supporting 3.3 V
      wr(`OFS_SOCKET_EVENT, 32'h0000_000F);
      wr(`OFS_SEQ_INPUTS, 32'h0000_0002);
      inserted <= 1'b1;
      tick(6);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0820);
      check(idents, 32'd1);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd, 32'h0000_0006);
      wr(`OFS_SEQ_INPUTS, 32'h0000_0001);
      tick(3);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0820);
      $display("END insertion");
      // Power up, event, mask and clear; request bit 1 selects 3.3 V
      wr(`OFS_SOCKET_CTRL, 32'h0000_0002);
      tick(4);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0828);
      check({31'h0, power_on}, 32'h1);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd, 32'h0000_000E);
      check({31'h0, irq}, 32'h0);
      wr(`OFS_SOCKET_MASK, 32'h0000_0008);
      tick(2);
      check({31'h0, irq}, 32'h1);
      wr(`OFS_SOCKET_EVENT, 32'h0000_0008);
      tick(2);
      check({31'h0, irq}, 32'h0);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd, 32'h0000_0006);
      $display("END power");
      // CardBus status change: rising edge only
      wr(`OFS_SOCKET_EVENT, 32'h0000_000F);
      sts <= 1'b1;
      tick(5);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd, 32'h0000_0001);
      wr(`OFS_SOCKET_EVENT, 32'h0000_0001);
      sts <= 1'b0;
      tick(5);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd, 32'h0000_0000);
      $display("END status change");
      // Removal while powered, then unrecognised card
      inserted <= 1'b0;
      tick(6);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd & 32'h0000_0136, 32'h0000_0126);
      wr(`OFS_SEQ_INPUTS, 32'h0000_0000);
      inserted <= 1'b1;
      tick(6);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd & 32'h0000_0080, 32'h0000_0080);
      inserted <= 1'b0;
      tick(6);
      wr(`OFS_SEQ_INPUTS, 32'h0000_0008);
      inserted <= 1'b1;
      tick(6);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd & 32'h0000_3CB0, 32'h0000_2010);
      wr(`OFS_SOCKET_CTRL, 32'h0000_0001);
      tick(4);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd & 32'h0000_0208, 32'h0000_0200);
      check(idents, 32'd3);
      // 16-bit card: falling status change also counts
      wr(`OFS_SOCKET_EVENT, 32'h0000_000F);
      sts <= 1'b1;
      tick(5);
      wr(`OFS_SOCKET_EVENT, 32'h0000_0001);
      sts <= 1'b0;
      tick(5);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      $display("END card types");
      // Force-event writes
      wr(`OFS_SOCKET_EVENT, 32'h0000_000F);
      wr(`OFS_FORCE_EVENT, 32'h0000_2001);
      tick(2);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h0000_2008);
      ahb(1'b0, `OFS_SOCKET_EVENT, 32'h0, rd);
      check(rd & 32'h0000_0001, 32'h0000_0001);
      ahb(1'b0, 12'h040, 32'h0, rd);
      check(rd, 32'h0000_0000);
      // Reinterrogation through the force register
      wr(`OFS_SEQ_INPUTS, 32'h0000_0002);
      wr(`OFS_FORCE_EVENT, 32'h0000_4000);
      tick(4);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h0000_0828);
      check(idents, 32'd4);
      $display("END force event");
      // Second reset in mid-run
      arst_n <= 1'b0;
      inserted <= 1'b0;
      tick(2);
      arst_n <= 1'b1;
      tick(4);
      ahb(1'b0, `OFS_SOCKET_STATUS, 32'h0, rd);
      check(rd, 32'h3000_0006);
      $display("END second reset");
      wrap_up();
   end
endmodule : tb_socket_present_state
